// ==== core/lpb_consts.vh ====
`ifndef LPB_CONSTS_VH
`define LPB_CONSTS_VH
// Command decode fields on the rising-edge command/address word.
`define LPB_CA_W 10
`define LPB_BANKS 8
`define LPB_ROW_W 14
`define LPB_COL_W 11
`define LPB_AB_BIT 4
`define LPB_BA_LSB 7
// Burst length codes.
`define LPB_BL4 2'h0
`define LPB_BL8 2'h1
`define LPB_BL16 2'h2
// Read latency reset value in clocks.
`define LPB_RL_RST 4'h3
`define LPB_PREAMBLE_CYC 1
`endif

// ==== core/lpb_device.v ====
`timescale 1ns/1ns
`include "lpb_consts.vh"
// Behaviour
// - Legality rules hold after exit with clock-enable high.
// - Mode read accepted while activating or precharging.
// - Mask low writes byte, high keeps byte.
// - Decode activate, open row in bank.
// - Decode column command, bit two picks read.
// - Start column from rising and falling bits.
// - Strobe preamble low, data on strobe edges.
// - Read latency comes from programmed value.
// - Gapless reads every half burst length; a new read here reruns latency and preamble, and cuts the burst in flight unless a beat lands on that edge.
// - Decode burst stop command.
// - Precharge closes all or one bank.
module lpb_device #(
    parameter MEM_DEPTH = 64,
    parameter AW = 6
) (
    // Clocks and reset.
    input wire CORE_CLK,
    input wire RST_B,
    // Command interface from the controller.
    input wire LINK_CK,
    input wire CKE,
    input wire CS_B,
    input wire [9:0] CA,
    // Write data path.
    input wire [7:0] WR_DATA,
    input wire WR_VALID,
    input wire WRITE_BYTE_MASK,
    // Configuration.
    input wire [3:0] READ_LATENCY,
    input wire [1:0] BURST_LENGTH,
    // Read data path.
    output reg [7:0] RD_DATA,
    output reg RD_STROBE,
    output reg RD_STROBE_OE,
    output reg RD_VALID,
    input wire RD_READY,
    // Status.
    output reg [7:0] BANK_OPEN,
    output reg MODE_READ_SEEN
);
    reg [2:0] ck_sync_reg;
    reg cke_s1_reg, cke_s2_reg, cke_prev_reg;
    reg cs_s1_reg, cs_s2_reg;
    reg [9:0] ca_s1_reg, ca_s2_reg;
    reg [7:0] wd_s1_reg, wd_s2_reg;
    reg wv_s1_reg, wv_s2_reg, dm_s1_reg, dm_s2_reg;
    reg [9:0] ca_rise_reg;
    reg cmd_pend_reg;
    reg [`LPB_ROW_W-1:0] open_row_reg [0:`LPB_BANKS-1];
    reg [7:0] mem_reg [0:MEM_DEPTH-1];
    reg [2:0] cur_bank_reg;
    reg [`LPB_COL_W-1:0] rd_col_reg, wr_col_reg;
    reg [4:0] rd_left_reg, wr_left_reg;
    reg [3:0] lat_cnt_reg;
    reg lat_run_reg, pre_reg;
    reg [7:0] buf0_reg, buf1_reg;
    reg [1:0] buf_cnt_reg;
    integer i;
    wire ck_rise = ck_sync_reg[1] & ~ck_sync_reg[2];
    wire ck_fall = ~ck_sync_reg[1] & ck_sync_reg[2];
    wire cke_ok = cke_s2_reg & cke_prev_reg;
    wire rise_cmd = ck_rise & ~cs_s2_reg & cke_ok;
    wire is_act = rise_cmd & ~ca_s2_reg[0] & ca_s2_reg[1];
    wire is_col = rise_cmd & ca_s2_reg[0] & ~ca_s2_reg[1];
    wire is_bst = rise_cmd & ca_s2_reg[0] & ca_s2_reg[1] & ~ca_s2_reg[2] & ~ca_s2_reg[3];
    wire is_pre = rise_cmd & ca_s2_reg[0] & ca_s2_reg[1] & ~ca_s2_reg[2] & ca_s2_reg[3];
    wire is_mrr = rise_cmd & ~ca_s2_reg[0] & ~ca_s2_reg[1] & ~ca_s2_reg[2] & ca_s2_reg[3];
    wire [`LPB_COL_W-1:0] start_col = {ca_s2_reg[9:1], ca_rise_reg[6:5]};
    wire [4:0] burst_beats = (BURST_LENGTH == `LPB_BL16) ? 5'h10 : (BURST_LENGTH == `LPB_BL8) ? 5'h08 : 5'h04;
    wire [AW-1:0] wr_addr = wr_col_reg[AW-1:0];
    wire [AW-1:0] rd_addr = rd_col_reg[AW-1:0];
    wire buf_ready = (buf_cnt_reg != 2'h2);
    wire beat_go = (rd_left_reg != 5'h00) & ~lat_run_reg & ~pre_reg & buf_ready & ck_sync_reg[1] != ck_sync_reg[2];
    always @(posedge CORE_CLK) begin
        ck_sync_reg <= {ck_sync_reg[1:0], LINK_CK};
        cke_s1_reg <= CKE;
        cke_s2_reg <= cke_s1_reg;
        cs_s1_reg <= CS_B;
        cs_s2_reg <= cs_s1_reg;
        ca_s1_reg <= CA;
        ca_s2_reg <= ca_s1_reg;
        wd_s1_reg <= WR_DATA;
        wd_s2_reg <= wd_s1_reg;
        wv_s1_reg <= WR_VALID;
        wv_s2_reg <= wv_s1_reg;
        dm_s1_reg <= WRITE_BYTE_MASK;
        dm_s2_reg <= dm_s1_reg;
        if (!RST_B) begin
            ck_sync_reg <= 3'h0;
            cke_prev_reg <= 1'b0;
            cmd_pend_reg <= 1'b0;
            ca_rise_reg <= 10'h000;
            cur_bank_reg <= 3'h0;
            rd_col_reg <= 11'h000;
            wr_col_reg <= 11'h000;
            rd_left_reg <= 5'h00;
            wr_left_reg <= 5'h00;
            lat_cnt_reg <= 4'h0;
            lat_run_reg <= 1'b0;
            pre_reg <= 1'b0;
            buf0_reg <= 8'h00;
            buf1_reg <= 8'h00;
            buf_cnt_reg <= 2'h0;
            RD_DATA <= 8'h00;
            RD_STROBE <= 1'b0;
            RD_STROBE_OE <= 1'b0;
            RD_VALID <= 1'b0;
            BANK_OPEN <= 8'h00;
            MODE_READ_SEEN <= 1'b0;
            for (i = 0; i < `LPB_BANKS; i = i + 1) begin
                open_row_reg[i] <= 14'h0000;
            end
        end else begin
            if (ck_rise) begin
                cke_prev_reg <= cke_s2_reg;
            end
            // The falling half of a column command completes the address.
            if (is_col) begin
                ca_rise_reg <= ca_s2_reg;
                cur_bank_reg <= ca_s2_reg[9:7];
                cmd_pend_reg <= 1'b1;
            end
            if (ck_fall && cmd_pend_reg) begin
                cmd_pend_reg <= 1'b0;
                if (ca_rise_reg[2]) begin
                    // A new read reruns latency and preamble, and restarts the burst unless a beat on the same edge keeps the old column and count.
                    rd_col_reg <= start_col;
                    rd_left_reg <= burst_beats;
                    lat_cnt_reg <= READ_LATENCY;
                    lat_run_reg <= 1'b1;
                end else begin
                    wr_col_reg <= start_col;
                    wr_left_reg <= burst_beats;
                end
            end
            if (is_act) begin
                BANK_OPEN[ca_s2_reg[9:7]] <= 1'b1;
                open_row_reg[ca_s2_reg[9:7]] <= {ca_s2_reg[6:2], ca_s2_reg[9:1]};
            end
            if (is_pre) begin
                if (ca_s2_reg[`LPB_AB_BIT]) begin
                    BANK_OPEN <= 8'h00;
                end else begin
                    BANK_OPEN[ca_s2_reg[9:7]] <= 1'b0;
                end
            end
            // Mode reads are honoured whatever the bank state.
            if (is_mrr) begin
                MODE_READ_SEEN <= 1'b1;
            end
            if (is_bst) begin
                rd_left_reg <= 5'h00;
                wr_left_reg <= 5'h00;
            end
            if (lat_run_reg && ck_rise) begin
                if (lat_cnt_reg <= 4'h1) begin
                    lat_run_reg <= 1'b0;
                    pre_reg <= 1'b1;
                    RD_STROBE_OE <= 1'b1;
                    RD_STROBE <= 1'b0;
                end else begin
                    lat_cnt_reg <= lat_cnt_reg - 4'h1;
                end
            end else if (pre_reg && ck_fall) begin
                pre_reg <= 1'b0;
            end
            // Each link edge after the preamble yields one beat with a strobe toggle, while the buffer has room.
            if (beat_go) begin
                RD_STROBE <= ~RD_STROBE;
                rd_col_reg <= rd_col_reg + 11'h001;
                rd_left_reg <= rd_left_reg - 5'h01;
            end else if (rd_left_reg == 5'h00 && !lat_run_reg && !pre_reg) begin
                // A burst cut by a stop may leave the strobe high, so park it low on release.
                RD_STROBE_OE <= 1'b0;
                RD_STROBE <= 1'b0;
            end
            // Write beats are taken on link edges only, since one beat spans many core clocks.
            if (wv_s2_reg && wr_left_reg != 5'h00 && ck_sync_reg[1] != ck_sync_reg[2]) begin
                if (!dm_s2_reg) begin
                    mem_reg[wr_addr] <= wd_s2_reg;
                end
                wr_col_reg <= wr_col_reg + 11'h001;
                wr_left_reg <= wr_left_reg - 5'h01;
            end
            // Two-entry buffer so a stalled receiver loses no beat.
            case ({beat_go, (RD_VALID & RD_READY)})
                2'b10: begin
                    if (buf_cnt_reg == 2'h0) buf0_reg <= mem_reg[rd_addr];
                    else buf1_reg <= mem_reg[rd_addr];
                    buf_cnt_reg <= buf_cnt_reg + 2'h1;
                end
                2'b01: begin
                    buf0_reg <= buf1_reg;
                    buf_cnt_reg <= buf_cnt_reg - 2'h1;
                end
                2'b11: begin
                    if (buf_cnt_reg == 2'h1) buf0_reg <= mem_reg[rd_addr];
                    else begin
                        buf0_reg <= buf1_reg;
                        buf1_reg <= mem_reg[rd_addr];
                    end
                end
                default: begin
                end
            endcase
            if (RD_READY || !RD_VALID) begin
                RD_VALID <= 1'b0;
                if (buf_cnt_reg != 2'h0 && !(RD_VALID && RD_READY && buf_cnt_reg == 2'h1)) begin
                    RD_VALID <= 1'b1;
                    RD_DATA <= (RD_VALID && RD_READY) ? buf1_reg : buf0_reg;
                end
            end
        end
    end
endmodule // lpb_device

// ==== dv/lpb_device_assertions.sv ====
`timescale 1ns/1ns
module lpb_device_checker (
    input wire CORE_CLK, input wire RST_B, input wire CKE, input wire CS_B, input wire RD_READY,
    input wire [7:0] RD_DATA, input wire RD_STROBE, input wire RD_STROBE_OE, input wire RD_VALID,
    input wire [7:0] BANK_OPEN, input wire MODE_READ_SEEN
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_preamble; RD_STROBE_OE && !RD_STROBE; endsequence
    sequence s_held; RD_VALID && $stable(RD_DATA); endsequence
    a_reset_clear: assert property ($rose(RST_B) |-> BANK_OPEN == 8'h00 && !RD_VALID && !MODE_READ_SEEN)
        else $error("outputs not cleared");
    a_read_held: assert property (RD_VALID && !RD_READY |=> s_held)
        else $error("read beat dropped while stalled");
    a_mode_sticky: assert property (MODE_READ_SEEN |=> MODE_READ_SEEN)
        else $error("mode read flag lost");
    a_mode_no_bank: assert property ($rose(MODE_READ_SEEN) |-> $stable(BANK_OPEN))
        else $error("mode read changed banks");
    a_strobe_preamble: assert property ($rose(RD_STROBE_OE) |-> s_preamble)
        else $error("strobe not low at enable");
    a_strobe_driven: assert property (RD_STROBE |-> RD_STROBE_OE)
        else $error("strobe high while released");
    a_cs_idle: assert property (CS_B [*8] |-> $stable(BANK_OPEN))
        else $error("banks changed while deselected");
    a_cke_refuse: assert property (!CKE [*8] |-> $stable(BANK_OPEN))
        else $error("banks changed with clock enable low");
endmodule // lpb_device_checker
bind lpb_device lpb_device_checker lpb_device_checker_i (.CORE_CLK, .RST_B, .CKE, .CS_B, .RD_READY, .RD_DATA,
    .RD_STROBE, .RD_STROBE_OE, .RD_VALID, .BANK_OPEN, .MODE_READ_SEEN);

// ==== dv/lpb_ctl.sv ====
`timescale 1ns/1ns
// Controller stand-in; its link clock stands low between frames.
module lpb_ctl (
    // Clock.
    input wire clk,
    // Command and write data toward the device.
    output reg link_ck,
    output reg cke,
    output reg cs_b,
    output reg [9:0] ca,
    output reg [7:0] wr_data,
    output reg wr_valid,
    output reg wr_mask
);
    initial {link_ck, cke, cs_b, ca, wr_data, wr_valid, wr_mask} = 23'h3f_fc00;
    task half(input lvl, input sel_b, input [9:0] a, input wv, input [7:0] d, input m);
        begin
            {link_ck, cs_b, ca, wr_valid, wr_data, wr_mask} <= {lvl, sel_b, a, wv, d, m};
            repeat (4) @(posedge clk);
        end
    endtask
    // A leading NOP period keeps enable seen at two rises and spaces commands out.
    // One command per frame with idle link between keeps every spacing.
    // No refresh or mode write is sent, a stop only follows a read, no burst is cut.
    task frame(input [9:0] r, input [9:0] f, input integer n, input wv, input [31:0] d, input [3:0] m);
        integer i;
        begin
            half(1, 1, ~r, 0, 8'h00, 0);
            half(0, 1, r, 0, 8'h00, 0);
            half(1, 0, r, 0, 8'h00, 0);
            half(0, 0, f, 0, 8'h00, 0);
            for (i = 0; i < 2 * n; i = i + 1)
                half(~i[0], 1, f ^ {10{i[0]}}, wv && i < 4, d[8 * (i & 3) +: 8], m[i & 3]);
        end
    endtask
endmodule // lpb_ctl

// ==== dv/lpb_device_tb.sv ====
`timescale 1ns/1ns
module lpb_device_tb;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg rd_ready = 1'b1;
    integer err_total = 0;
    integer check_count = 0;
    integer n_got = 0;
    reg [7:0] got [0:7];
    wire link_ck, cke, cs_b, wr_valid, wr_mask, rd_strobe, rd_oe, rd_valid, mode_seen;
    wire [9:0] ca;
    wire [7:0] wr_data, rd_data, bank_open;
    always #20 clk = ~clk;
    lpb_ctl lpb_ctl_i (.clk(clk), .link_ck(link_ck), .cke(cke), .cs_b(cs_b), .ca(ca), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_mask(wr_mask));
    lpb_device lpb_device_i (.CORE_CLK(clk), .RST_B(rst_b), .LINK_CK(link_ck), .CKE(cke), .CS_B(cs_b), .CA(ca),
        .WR_DATA(wr_data), .WR_VALID(wr_valid), .WRITE_BYTE_MASK(wr_mask), .READ_LATENCY(4'h3),
        .BURST_LENGTH(2'h0), .RD_DATA(rd_data), .RD_STROBE(rd_strobe), .RD_STROBE_OE(rd_oe),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .BANK_OPEN(bank_open), .MODE_READ_SEEN(mode_seen));
    always @(posedge clk)
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            got[n_got & 7] = rd_data;
            n_got = n_got + 1;
        end
    task chk(input [79:0] nm, input [7:0] exp, input [7:0] act);
        begin
            check_count = check_count + 1;
            if (act !== exp)
                $display("[ERR] %0s expected %h seen %h", nm, exp, act);
            if (act !== exp)
                err_total = err_total + 1;
        end
    endtask
    task t_bank;
        begin
            lpb_ctl_i.frame(10'h182, 10'h000, 1, 0, 0, 0);
            chk("bank_open", 8'h08, bank_open);
            lpb_ctl_i.cke <= 1'b0;
            lpb_ctl_i.frame(10'h282, 10'h000, 1, 0, 0, 0);
            chk("bank_open", 8'h08, bank_open);
            lpb_ctl_i.cke <= 1'b1;
        end
    endtask
    task t_data;
        begin
            lpb_ctl_i.frame(10'h181, 10'h000, 3, 1, 32'h4433_2211, 4'h0);
            lpb_ctl_i.frame(10'h181, 10'h000, 3, 1, 32'h8877_6655, 4'h2);
            rd_ready <= 1'b0;
            lpb_ctl_i.frame(10'h185, 10'h000, 7, 0, 0, 0);
            chk("rd_valid", 8'h01, {7'h00, rd_valid});
            chk("rd_data", 8'h55, rd_data);
            rd_ready <= 1'b1;
            lpb_ctl_i.frame(10'h003, 10'h000, 1, 0, 0, 0);
            chk("stall_beats", 8'h04, n_got[7:0]);
            chk("stall_last", 8'h88, got[3]);
            n_got = 0;
            lpb_ctl_i.frame(10'h185, 10'h000, 7, 0, 0, 0);
            chk("beats", 8'h04, n_got[7:0]);
            chk("beat0", 8'h55, got[0]);
            chk("beat1", 8'h22, got[1]);
            chk("beat2", 8'h77, got[2]);
            chk("beat3", 8'h88, got[3]);
        end
    endtask
    task t_mode;
        begin
            lpb_ctl_i.frame(10'h008, 10'h000, 2, 0, 0, 0);
            chk("mode_seen", 8'h01, {7'h00, mode_seen});
            lpb_ctl_i.frame(10'h302, 10'h000, 1, 0, 0, 0);
            lpb_ctl_i.frame(10'h18b, 10'h000, 1, 0, 0, 0);
            chk("bank_open", 8'h40, bank_open);
            lpb_ctl_i.frame(10'h01b, 10'h000, 1, 0, 0, 0);
            chk("bank_open", 8'h00, bank_open);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_bank;
        t_data;
        t_mode;
        end_sim;
    end
endmodule // lpb_device_tb
